// File: rtl/dma_pkg.sv
package dma_pkg;

  // Structure of the engine
  localparam int NUM_CH = 7;
  localparam int CH_W = 3;
  localparam int BASE_W = 12;
  localparam int OFS_W = 10;
  localparam int DATA_W = 8;
  localparam int FUNC_W = 3;
  localparam int BUS_W = 32;
  localparam int ADDR_W = 8;

  // Register byte addresses, one aligned word each
  localparam logic [7:0] A_SEL = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_WRAP = 8'h08;
  localparam logic [7:0] A_BASE = 8'h0c;
  localparam logic [7:0] A_OFS = 8'h10;
  localparam logic [7:0] A_LEN = 8'h14;
  localparam logic [7:0] A_EN = 8'h18;
  localparam logic [7:0] A_FULL = 8'h1c;
  localparam logic [7:0] A_MID = 8'h20;
  localparam logic [7:0] A_BUSY = 8'h24;

  // Channel control register fields
  localparam int CF_FUNC_LSB = 0;
  localparam int CF_ENDIAN_BIT = 4;
  localparam int CF_STALL_BIT = 5;
  localparam int CF_MID_EN_BIT = 6;
  localparam int CF_FULL_EN_BIT = 7;
  localparam int WRAP_BIT = 0;

  // Reset values
  localparam logic [7:0] CF_RESET = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h00000000;

  // Transfer function codes
  localparam logic [2:0] FN_RAM_TO_ENC = 3'h0;
  localparam logic [2:0] FN_ENC_TO_RAM = 3'h1;
  localparam logic [2:0] FN_RAM_TO_CRC = 3'h2;
  localparam logic [2:0] FN_RAM_TO_SPI = 3'h3;
  localparam logic [2:0] FN_SPI_TO_RAM = 3'h4;
  localparam logic [2:0] FN_RAM_TO_KEY = 3'h5;
  localparam logic [2:0] FN_RAM_TO_BLK = 3'h6;
  localparam logic [2:0] FN_OUT_TO_RAM = 3'h7;

  // Engine sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_FETCH = 2'b10
  } state_t;

endpackage : dma_pkg

// File: rtl/seven_channel_sfr_on_chip_data_ram_dma.sv
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
module seven_channel_sfr_on_chip_data_ram_dma #(
  parameter int NUM_CH = dma_pkg::NUM_CH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Avalon-MM register slave
  input wire logic [dma_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [dma_pkg::BUS_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [dma_pkg::BUS_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Peripheral requests and acknowledges
  input wire logic [NUM_CH-1:0] req_i,
  output logic [NUM_CH-1:0] ack_o,
  // Data RAM port, read data valid in the cycle of the read
  output logic [dma_pkg::BASE_W-1:0] ram_addr_o,
  output logic ram_rd_o,
  output logic ram_wr_o,
  output logic [dma_pkg::DATA_W-1:0] ram_wdata_o,
  input wire logic [dma_pkg::DATA_W-1:0] ram_rdata_i,
  // Peripheral register port, read bytes packed by function code
  output logic [dma_pkg::FUNC_W-1:0] sfr_func_o,
  output logic sfr_wr_o,
  output logic sfr_rd_o,
  output logic [dma_pkg::DATA_W-1:0] sfr_wdata_o,
  input wire logic [8*dma_pkg::DATA_W-1:0] sfr_rdata_i,
  // System control
  input wire logic cpu_bus_busy_i,
  input wire logic debug_halt_i,
  output logic engine_idle_o
);

  localparam int CH_W = dma_pkg::CH_W;
  localparam int BASE_W = dma_pkg::BASE_W;
  localparam int OFS_W = dma_pkg::OFS_W;
  localparam int BUS_W = dma_pkg::BUS_W;

  // Merge write data into an old value under the byte enables
  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge_be = (old_v & ~m) | (new_v & m);
  endfunction : merge_be

  // Midpoint offset: half the size, plus one when size is odd
  function automatic logic [OFS_W-1:0] midpoint(input logic [OFS_W-1:0] len);
    midpoint = len[0] ? (len >> 1) + OFS_W'(1) : (len >> 1);
  endfunction : midpoint

  // Functions that move a register byte into RAM
  function automatic logic reg_to_ram(input logic [2:0] fn);
    reg_to_ram = (fn == dma_pkg::FN_ENC_TO_RAM) || (fn == dma_pkg::FN_SPI_TO_RAM)
                 || (fn == dma_pkg::FN_OUT_TO_RAM);
  endfunction : reg_to_ram
  // Index of the single set bit of a one-hot vector
  function automatic logic [CH_W-1:0] oh_to_idx(input logic [NUM_CH-1:0] oh);
    oh_to_idx = '0;
    for (int i = 0; i < NUM_CH; i++)
      if (oh[i])
        oh_to_idx = CH_W'(i);
  endfunction : oh_to_idx
  // Reset release through two flip-flops
  logic [1:0] rst_sync_r;
  wire rst_n = rst_sync_r[1];
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  // Register and engine state
  logic [2:0] sel_r;
  logic [7:0] cf_r [NUM_CH];
  logic [BASE_W-1:0] ba_r [NUM_CH];
  logic [OFS_W-1:0] ofs_r [NUM_CH];
  logic [OFS_W-1:0] len_r [NUM_CH];
  logic [NUM_CH-1:0] wrap_r, en_r, full_r, mid_r, force_r, done_r, ack_r;
  logic wait_r;
  logic [BUS_W-1:0] rdata_r;
  dma_pkg::state_t state_r;
  logic [CH_W-1:0] cur_r;
  logic [BASE_W-1:0] ram_addr_r;
  logic ram_rd_r, ram_wr_r, sfr_wr_r, sfr_rd_r, idle_r;
  logic [7:0] ram_wdata_r, sfr_wdata_r;
  logic [2:0] sfr_func_r;

  // Bus decode; a write takes effect on the edge after the wait, while waitrequest is low
  wire bus_req = avs_read_i | avs_write_i;
  wire wr_acc = avs_write_i & ~wait_r;
  wire hit_sel = avs_address_i == dma_pkg::A_SEL;
  wire hit_cf = avs_address_i == dma_pkg::A_CTRL;
  wire hit_wrap = avs_address_i == dma_pkg::A_WRAP;
  wire hit_ba = avs_address_i == dma_pkg::A_BASE;
  wire hit_ofs = avs_address_i == dma_pkg::A_OFS;
  wire hit_len = avs_address_i == dma_pkg::A_LEN;
  wire hit_en = avs_address_i == dma_pkg::A_EN;
  wire hit_full = avs_address_i == dma_pkg::A_FULL;
  wire hit_mid = avs_address_i == dma_pkg::A_MID;
  wire hit_busy = avs_address_i == dma_pkg::A_BUSY;
  // Selected channel view; select value seven names no channel
  wire sel_ok = sel_r < 3'(NUM_CH);
  wire [CH_W-1:0] si = sel_ok ? sel_r : '0;
  wire [7:0] cf_sel = sel_ok ? cf_r[si] : '0;
  wire [BASE_W-1:0] ba_sel = sel_ok ? ba_r[si] : '0;
  wire [OFS_W-1:0] ofs_sel = sel_ok ? ofs_r[si] : '0;
  wire [OFS_W-1:0] len_sel = sel_ok ? len_r[si] : '0;
  wire wrap_sel = sel_ok & wrap_r[si];
  // Busy is a forced request or the channel in the sequencer
  wire fetching = state_r == dma_pkg::ST_FETCH;
  wire [NUM_CH-1:0] fetch_vec = fetching ? (NUM_CH'(1) << cur_r) : '0;
  wire [NUM_CH-1:0] busy_vec = force_r | fetch_vec;
  wire sel_busy = sel_ok & busy_vec[si];
  // Write strobes per register
  wire we_sel = wr_acc & hit_sel;
  wire we_cf = wr_acc & hit_cf & sel_ok;
  wire we_wrap = wr_acc & hit_wrap & sel_ok;
  wire we_ba = wr_acc & hit_ba & sel_ok;
  wire we_ofs = wr_acc & hit_ofs & sel_ok;
  wire we_len = wr_acc & hit_len & sel_ok;
  wire we_en = wr_acc & hit_en;
  wire we_full = wr_acc & hit_full;
  wire we_mid = wr_acc & hit_mid;
  wire we_busy = wr_acc & hit_busy;
  wire [NUM_CH-1:0] sel_oh = NUM_CH'(1) << si;
  // Merged write values
  wire [31:0] w_sel = merge_be({29'h0, sel_r}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] w_cf = merge_be({24'h0, cf_sel}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] w_wrap = merge_be({31'h0, wrap_sel}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] w_ba = merge_be({{(32-BASE_W){1'b0}}, ba_sel}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] w_ofs = merge_be({{(32-OFS_W){1'b0}}, ofs_sel}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] w_len = merge_be({{(32-OFS_W){1'b0}}, len_sel}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] w_en = merge_be({{(32-NUM_CH){1'b0}}, en_r}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] w_full = merge_be({{(32-NUM_CH){1'b0}}, full_r}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] w_mid = merge_be({{(32-NUM_CH){1'b0}}, mid_r}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] w_busy = merge_be(32'h0, avs_writedata_i, avs_byteenable_i);
  // Read multiplexer; unmapped addresses read zero
  wire [BUS_W-1:0] rd_mux =
    hit_sel ? {29'h0, sel_r} :
    hit_cf ? {24'h0, cf_sel} :
    hit_wrap ? {31'h0, wrap_sel} :
    hit_ba ? {{(32-BASE_W){1'b0}}, ba_sel} :
    hit_ofs ? {{(32-OFS_W){1'b0}}, ofs_sel} :
    hit_len ? {{(32-OFS_W){1'b0}}, len_sel} :
    hit_en ? {{(32-NUM_CH){1'b0}}, en_r} :
    hit_full ? {{(32-NUM_CH){1'b0}}, full_r} :
    hit_mid ? {{(32-NUM_CH){1'b0}}, mid_r} :
    hit_busy ? {{(32-NUM_CH){1'b0}}, busy_vec} : dma_pkg::RD_ZERO;
  // Per-channel decode of control bits and offset compares
  logic [NUM_CH-1:0] stall_vec, last_vec, mid_hit, in_vec;
  logic [2:0] func_vec [NUM_CH];
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    assign func_vec[c] = cf_r[c][dma_pkg::CF_FUNC_LSB +: dma_pkg::FUNC_W];
    assign stall_vec[c] = cf_r[c][dma_pkg::CF_STALL_BIT];
    assign in_vec[c] = reg_to_ram(func_vec[c]);
    assign last_vec[c] = ofs_r[c] == len_r[c] - OFS_W'(1);
    assign mid_hit[c] = ofs_r[c] == midpoint(len_r[c]);
  end
  // Eligible channels; the channel just served sits out its ack cycle
  wire [NUM_CH-1:0] want = en_r & ((req_i & ~done_r) | force_r)
                           & ~stall_vec & ~full_r & ~mid_r
                           & ~ack_r & ~fetch_vec;
  wire [NUM_CH-1:0] grant_oh = want & (~want + NUM_CH'(1));
  wire [CH_W-1:0] g_idx = oh_to_idx(grant_oh);
  wire [2:0] g_func = func_vec[g_idx];
  wire g_in = in_vec[g_idx];
  wire [BASE_W-1:0] g_addr = ba_r[g_idx] + BASE_W'(ofs_r[g_idx]);
  // Bus is ours only when the CPU and the debugger leave it
  wire bus_free = ~cpu_bus_busy_i & ~debug_halt_i;
  wire finish = fetching & bus_free;
  wire idle = state_r == dma_pkg::ST_IDLE;
  wire can_start = (|want) & bus_free & (idle | (finish & ~g_in));
  wire [NUM_CH-1:0] step_vec = (finish ? fetch_vec : '0)
                               | ((can_start & g_in) ? grant_oh : '0);
  // Flag sets from the byte just moved
  logic [NUM_CH-1:0] full_set, mid_set;
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_flag
    assign full_set[c] = step_vec[c] & last_vec[c] & cf_r[c][dma_pkg::CF_FULL_EN_BIT];
    assign mid_set[c] = step_vec[c] & mid_hit[c] & cf_r[c][dma_pkg::CF_MID_EN_BIT];
  end

  // Avalon slave: one wait cycle, then read data with waitrequest low
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_r <= 1'b1;
      rdata_r <= dma_pkg::RD_ZERO;
    end
    else if (bus_req && wait_r)
    begin
      wait_r <= 1'b0;
      rdata_r <= rd_mux;
    end
    else
      wait_r <= 1'b1;
  end

  // Common registers; hardware set wins over a software clear
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_r <= 3'h0;
      en_r <= '0;
      full_r <= '0;
      mid_r <= '0;
      force_r <= '0;
    end
    else
    begin
      if (we_sel)
        sel_r <= w_sel[CH_W-1:0];
      if (we_en)
        en_r <= w_en[NUM_CH-1:0];
      full_r <= full_set | (we_full ? w_full[NUM_CH-1:0] : full_r);
      mid_r <= mid_set | (we_mid ? w_mid[NUM_CH-1:0] : mid_r);
      force_r <= (force_r & ~step_vec) | (we_busy ? w_busy[NUM_CH-1:0] : '0);
    end
  end

  // Per-channel configuration and offset counters
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrap_r <= '0;
      done_r <= '0;
      for (int c = 0; c < NUM_CH; c++)
      begin
        cf_r[c] <= dma_pkg::CF_RESET;
        ba_r[c] <= '0;
        ofs_r[c] <= '0;
        len_r[c] <= '0;
      end
    end
    else
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (we_cf && sel_oh[c])
          cf_r[c] <= w_cf[7:0];
        if (we_wrap && sel_oh[c])
          wrap_r[c] <= w_wrap[dma_pkg::WRAP_BIT];
        if (we_ba && sel_oh[c] && !busy_vec[c])
          ba_r[c] <= w_ba[BASE_W-1:0];
        if (we_len && sel_oh[c] && !busy_vec[c])
          len_r[c] <= w_len[OFS_W-1:0];
        if (step_vec[c])
        begin
          ofs_r[c] <= (last_vec[c] && wrap_r[c]) ? '0 : ofs_r[c] + OFS_W'(1);
          if (last_vec[c] && !wrap_r[c])
            done_r[c] <= 1'b1;
        end
        else if (we_ofs && sel_oh[c] && !busy_vec[c])
        begin
          ofs_r[c] <= w_ofs[OFS_W-1:0];
          done_r[c] <= 1'b0;
        end
      end
    end
  end

  // Sequencer and bus strobes
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= dma_pkg::ST_IDLE;
      cur_r <= '0;
      ram_addr_r <= '0;
      ram_rd_r <= 1'b0;
      ram_wr_r <= 1'b0;
      ram_wdata_r <= 8'h00;
      sfr_func_r <= 3'h0;
      sfr_wr_r <= 1'b0;
      sfr_rd_r <= 1'b0;
      sfr_wdata_r <= 8'h00;
      ack_r <= '0;
      idle_r <= 1'b1;
    end
    else
    begin
      ram_wr_r <= 1'b0;
      sfr_rd_r <= 1'b0;
      sfr_wr_r <= 1'b0;
      ack_r <= step_vec;
      idle_r <= idle & ~(|want);
      if (!fetching || finish)
        ram_rd_r <= 1'b0; // Held until its data is taken
      case (state_r)
        dma_pkg::ST_FETCH:
        begin
          if (finish)
          begin
            sfr_wr_r <= 1'b1;
            sfr_wdata_r <= ram_rdata_i;
            sfr_func_r <= func_vec[cur_r];
            state_r <= dma_pkg::ST_IDLE;
          end
        end
        default:
          state_r <= dma_pkg::ST_IDLE;
      endcase
      if (can_start)
      begin
        cur_r <= g_idx;
        ram_addr_r <= g_addr;
        if (g_in)
        begin
          ram_wr_r <= 1'b1;
          ram_wdata_r <= sfr_rdata_i[{g_func, 3'b000} +: 8];
          sfr_rd_r <= 1'b1;
          sfr_func_r <= g_func;
        end
        else
        begin
          ram_rd_r <= 1'b1;
          state_r <= dma_pkg::ST_FETCH;
        end
      end
    end
  end

  // Outputs from flip-flops
  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign ack_o = ack_r;
  assign ram_addr_o = ram_addr_r;
  assign ram_rd_o = ram_rd_r;
  assign ram_wr_o = ram_wr_r;
  assign ram_wdata_o = ram_wdata_r;
  assign sfr_func_o = sfr_func_r;
  assign sfr_wr_o = sfr_wr_r;
  assign sfr_rd_o = sfr_rd_r;
  assign sfr_wdata_o = sfr_wdata_r;
  assign engine_idle_o = idle_r;
  // Checks on the engine
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);
  a_ram_to_reg: assert property (fetching && bus_free |=> sfr_wr_o
    && ack_o == $past(fetch_vec) && ram_rd_o == $past(can_start))
    else $error("RAM-to-register write not in second cycle");
  a_reg_to_ram: assert property (can_start && g_in |=> ram_wr_o && sfr_rd_o
    && ack_o == $past(grant_oh)
    ##1 (ack_o & $past(grant_oh, 2)) == '0)
    else $error("Register-to-RAM move not a single cycle");
  a_cpu_wins: assert property (cpu_bus_busy_i |=> !ram_wr_o && !sfr_wr_o && !sfr_rd_o)
    else $error("Engine used the bus while the CPU held it");
  a_prio_fixed: assert property (can_start |->
    (want & ((NUM_CH'(1) << g_idx) - NUM_CH'(1))) == '0)
    else $error("Lower priority channel granted first");
  a_stall_block: assert property (can_start |-> !stall_vec[g_idx] && en_r[g_idx])
    else $error("Stalled or disabled channel started");
  a_flag_block: assert property (can_start |-> !full_r[g_idx] && !mid_r[g_idx])
    else $error("Channel started with a flag pending");
  a_busy_ignore: assert property (we_ba && sel_busy |=> $stable(ba_sel))
    else $error("Base written while channel busy");
  a_wrap_zero: assert property ((|(step_vec & last_vec & wrap_r)) |=>
    ofs_r[$past(oh_to_idx(step_vec & last_vec & wrap_r))] == '0)
    else $error("Wrapping offset did not return to zero");
  a_full_set: assert property (step_vec[0] && last_vec[0]
    && cf_r[0][dma_pkg::CF_FULL_EN_BIT] |=> full_r[0] && ack_o[0])
    else $error("Full flag not set at last byte");
endmodule : seven_channel_sfr_on_chip_data_ram_dma

// File: tb/periph_model.sv
module periph_model (
  // Clock
  input wire logic clk_i,
  // Request levels
  input wire logic [6:0] want_i,
  output logic [6:0] req_o,
  // Data RAM side
  input wire logic [11:0] ram_addr_i,
  input wire logic ram_rd_i,
  input wire logic ram_wr_i,
  input wire logic [7:0] ram_wdata_i,
  output logic [7:0] ram_rdata_o,
  // Register side
  input wire logic sfr_rd_i,
  output logic [63:0] sfr_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [4096];
  logic [7:0] pops = 8'h00;

  // Each peripheral raises its own request
  assign req_o = want_i;
  // Unread RAM lines show inverted data so stale values never pass
  assign ram_rdata_o = ram_rd_i ? mem[ram_addr_i] : ~mem[ram_addr_i];

  // Register byte k carries k and the pop count
  always_comb
    for (int k = 0; k < 8; k++)
      sfr_rdata_o[8*k +: 8] = {k[2:0], pops[4:0]};

  // Known RAM contents
  initial
    for (int i = 0; i < 4096; i++)
      mem[i] = i[7:0] ^ 8'h5a;

  // RAM writes and register pops
  always @(posedge clk_i)
  begin
    if (ram_wr_i)
      mem[ram_addr_i] <= ram_wdata_i;
    if (sfr_rd_i)
      pops <= pops + 8'h01;
  end
endmodule : periph_model

// File: tb/tb_seven_channel_sfr_on_chip_data_ram_dma.sv
module tb_seven_channel_sfr_on_chip_data_ram_dma;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdata;
  logic waitreq;
  logic [6:0] want = 7'h00;
  logic [6:0] req;
  logic [6:0] ack;
  logic [11:0] ram_addr;
  logic ram_rd;
  logic ram_wr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_wdata;
  logic [63:0] sfr_rdata;
  logic [2:0] sfr_func;
  logic [2:0] last_func = 3'h0;
  logic cpu_busy = 1'b0;
  logic halt = 1'b0;
  logic idle;
  logic rd_seen = 1'b0;
  int bad_count = 0;
  int checks = 0;
  int acks [7] = '{default: 0};
  logic [7:0] wlog [$];
  logic [31:0] q;

  seven_channel_sfr_on_chip_data_ram_dma #(.NUM_CH(7)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .req_i(req), .ack_o(ack),
    .ram_addr_o(ram_addr), .ram_rd_o(ram_rd), .ram_wr_o(ram_wr),
    .ram_wdata_o(ram_wdata), .ram_rdata_i(ram_rdata), .sfr_func_o(sfr_func),
    .sfr_wr_o(sfr_wr), .sfr_rd_o(sfr_rd), .sfr_wdata_o(sfr_wdata),
    .sfr_rdata_i(sfr_rdata), .cpu_bus_busy_i(cpu_busy), .debug_halt_i(halt),
    .engine_idle_o(idle));

  periph_model pm (
    .clk_i(clk_i), .want_i(want), .req_o(req), .ram_addr_i(ram_addr),
    .ram_rd_i(ram_rd), .ram_wr_i(ram_wr), .ram_wdata_i(ram_wdata),
    .ram_rdata_o(ram_rdata), .sfr_rd_i(sfr_rd), .sfr_rdata_o(sfr_rdata));

  // Clock generator
  initial
    forever #20 clk_i = ~clk_i;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Count bytes per channel, log register writes
  always @(posedge clk_i)
  begin
    for (int i = 0; i < 7; i++)
      if (ack[i] === 1'b1)
        acks[i]++;
    if (sfr_wr === 1'b1)
    begin
      wlog.push_back(sfr_wdata);
      chk({31'h0, rd_seen}, 32'h1);
    end
    rd_seen = ram_rd;
    if (sfr_wr === 1'b1 || sfr_rd === 1'b1)
      last_func = sfr_func;
  end

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    @(posedge clk_i);
    while (waitreq !== 1'b0)
      @(posedge clk_i);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rchk

  task automatic cfg(input logic [2:0] ch, input logic [7:0] cf, input logic [11:0] base,
                     input logic [9:0] len, input logic w);
    bus(1'b1, dma_pkg::A_SEL, {29'h0, ch});
    bus(1'b1, dma_pkg::A_CTRL, {24'h0, cf});
    bus(1'b1, dma_pkg::A_WRAP, {31'h0, w});
    bus(1'b1, dma_pkg::A_BASE, {20'h0, base});
    bus(1'b1, dma_pkg::A_LEN, {22'h0, len});
    bus(1'b1, dma_pkg::A_OFS, 32'h0);
  endtask : cfg

  task automatic t_regs();
    rchk(dma_pkg::A_EN, 32'h0);
    rchk(8'h3c, 32'h0);
    bus(1'b1, 8'h3c, 32'hffffffff);
    rchk(8'h3c, 32'h0);
    bus(1'b1, dma_pkg::A_SEL, 32'hffffffff);
    rchk(dma_pkg::A_SEL, 32'h7);
    bus(1'b1, dma_pkg::A_CTRL, 32'hff);
    rchk(dma_pkg::A_CTRL, 32'h0);
    cfg(3'h3, 8'h26, 12'h0, 10'h0, 1'b1);
    bus(1'b1, dma_pkg::A_BASE, 32'hffffffff);
    rchk(dma_pkg::A_BASE, 32'hfff);
    bus(1'b1, dma_pkg::A_LEN, 32'hffffffff);
    rchk(dma_pkg::A_LEN, 32'h3ff);
    cfg(3'h0, 8'h11, 12'h0, 10'h0, 1'b0);
    be <= 4'h0;
    bus(1'b1, dma_pkg::A_SEL, 32'h5);
    be <= 4'hf;
    rchk(dma_pkg::A_CTRL, 32'h11);
    bus(1'b1, dma_pkg::A_SEL, 32'h3);
    rchk(dma_pkg::A_CTRL, 32'h26);
    rchk(dma_pkg::A_WRAP, 32'h1);
  endtask : t_regs

  task automatic t_wr_ram();
    int p0;
    p0 = pm.pops;
    cfg(3'h0, 8'hc1, 12'h100, 10'd4, 1'b0);
    bus(1'b1, dma_pkg::A_EN, 32'h1);
    want[0] <= 1'b1;
    repeat (30) @(posedge clk_i);
    chk(acks[0], 32'd3);
    rchk(dma_pkg::A_MID, 32'h1);
    rchk(dma_pkg::A_FULL, 32'h0);
    bus(1'b1, dma_pkg::A_MID, 32'h0);
    repeat (20) @(posedge clk_i);
    chk(acks[0], 32'd4);
    rchk(dma_pkg::A_FULL, 32'h1);
    rchk(dma_pkg::A_OFS, 32'd4);
    for (int i = 0; i < 4; i++)
      chk({24'h0, pm.mem[12'h100 + i]}, {24'h0, 3'd1, 5'(p0 + i)});
    chk({29'h0, last_func}, {29'h0, dma_pkg::FN_ENC_TO_RAM});
    bus(1'b1, dma_pkg::A_FULL, 32'h0);
    repeat (20) @(posedge clk_i);
    chk(acks[0], 32'd4);
    want[0] <= 1'b0;
  endtask : t_wr_ram

  task automatic t_ram_reg();
    wlog.delete();
    cfg(3'h1, 8'h43, 12'h200, 10'd5, 1'b0);
    bus(1'b1, dma_pkg::A_EN, 32'h2);
    want[1] <= 1'b1;
    repeat (30) @(posedge clk_i);
    chk(acks[1], 32'd4);
    rchk(dma_pkg::A_MID, 32'h2);
    bus(1'b1, dma_pkg::A_MID, 32'h0);
    repeat (20) @(posedge clk_i);
    chk(acks[1], 32'd5);
    rchk(dma_pkg::A_FULL, 32'h0);
    chk(wlog.size(), 32'd5);
    chk({29'h0, last_func}, {29'h0, dma_pkg::FN_RAM_TO_SPI});
    for (int i = 0; i < 5; i++)
      chk({24'h0, wlog[i]}, {24'h0, 8'(i) ^ 8'h5a});
    want[1] <= 1'b0;
  endtask : t_ram_reg

  task automatic t_wrap();
    wlog.delete();
    cfg(3'h2, 8'h05, 12'h300, 10'd3, 1'b1);
    bus(1'b1, dma_pkg::A_EN, 32'h4);
    want[2] <= 1'b1;
    repeat (40) @(posedge clk_i);
    want[2] <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk({31'h0, acks[2] > 6}, 32'h1);
    rchk(dma_pkg::A_OFS, 32'(acks[2] % 3));
    chk({29'h0, last_func}, {29'h0, dma_pkg::FN_RAM_TO_KEY});
    for (int i = 0; i < wlog.size(); i++)
      chk({24'h0, wlog[i]}, {24'h0, 8'(i % 3) ^ 8'h5a});
  endtask : t_wrap

  task automatic t_arb();
    int n;
    n = 0;
    cfg(3'h5, 8'h01, 12'h500, 10'd8, 1'b0);
    cfg(3'h3, 8'h21, 12'h400, 10'd8, 1'b0);
    bus(1'b1, dma_pkg::A_EN, 32'h08);
    want <= 7'h28;
    repeat (20) @(posedge clk_i);
    chk(acks[3], 32'd0);
    chk(acks[5], 32'd0);
    want <= 7'h00;
    bus(1'b1, dma_pkg::A_CTRL, 32'h01);
    bus(1'b1, dma_pkg::A_EN, 32'h28);
    want <= 7'h28;
    @(posedge clk_i);
    while (ack === 7'h00 && n < 20)
    begin
      n++;
      @(posedge clk_i);
    end
    chk({25'h0, ack}, 32'h08);
    want <= 7'h00;
    repeat (10) @(posedge clk_i);
  endtask : t_arb

  task automatic t_force();
    int p0;
    int n;
    n = 0;
    cfg(3'h6, 8'h01, 12'h600, 10'd8, 1'b0);
    bus(1'b1, dma_pkg::A_EN, 32'h40);
    cpu_busy <= 1'b1;
    p0 = pm.pops;
    bus(1'b1, dma_pkg::A_BUSY, 32'h40);
    rchk(dma_pkg::A_BUSY, 32'h40);
    bus(1'b1, dma_pkg::A_BASE, 32'h7ff);
    rchk(dma_pkg::A_BASE, 32'h600);
    repeat (10) @(posedge clk_i);
    chk(acks[6], 32'd0);
    cpu_busy <= 1'b0;
    halt <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk(acks[6], 32'd0);
    halt <= 1'b0;
    q = 32'h1;
    while (q !== 32'h0 && n < 20)
    begin
      n++;
      bus(1'b0, dma_pkg::A_BUSY, 32'h0);
    end
    chk(acks[6], 32'd1);
    chk({24'h0, pm.mem[12'h600]}, {24'h0, 3'd1, 5'(p0)});
    repeat (5) @(posedge clk_i);
    chk({31'h0, idle}, 32'h1);
  endtask : t_force

  task automatic tally_and_finish();
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk_i);
    chk({30'h0, waitreq, idle}, 32'h3);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_regs();
    t_wr_ram();
    t_ram_reg();
    t_wrap();
    t_arb();
    t_force();
    tally_and_finish();
  end
endmodule : tb_seven_channel_sfr_on_chip_data_ram_dma
